// ---- design/bmc_map.svh ----
// Register offsets, field positions, reset values and timing counts of the line timing block
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH
`define BMC_ADDR_W 16
`define BMC_OFS_SQL_ASSERT 16'h1AA8
`define BMC_OFS_SQL_HOLD 16'h1AA9
`define BMC_OFS_TX_BIT 16'h1AB0
`define BMC_OFS_IDLE_WIN 16'h1AB1
`define BMC_OFS_ST_CTL_A 16'h1AC0
`define BMC_RST_TIMING 8'h00
`define BMC_RST_ST_CTL_A 8'h00
`define BMC_ST_RX_EN_BIT 4
`define BMC_ST_EN_BIT 3
`define BMC_ST_MODE_MSB 2
`define BMC_ST_WR_MASK 8'h1F
`define BMC_TICK_DIV 2'h3
`define BMC_EDGES_NEEDED 2'h3
`endif

// ---- design/bmc_pkg.sv ----
// Types shared by the line timing block
package bmc_pkg;
  typedef enum logic [1:0] {
    BMC_SQ_OFF = 2'b00,
    BMC_SQ_ON = 2'b01,
    BMC_SQ_HOLD = 2'b10
  } bmc_sq_state_t;
endpackage

// ---- design/bmc_edge_window.sv ----
// Counts line edges inside a tick-based window and flags three edges seen
`timescale 1ns/1ps
`include "bmc_map.svh"
module bmc_edge_window #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic tick,
  input wire logic edge_seen,
  input wire logic [W-1:0] limit,
  input wire logic add_one,
  // Results
  output logic hit,
  output logic expired
);
  logic [W:0] tmr_ff;
  logic [1:0] cnt_ff;
  logic [W:0] nxt_tmr;
  logic [1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;
  // Window end: limit ticks, plus one extra clock when asked
  wire logic [W:0] lim_ext = {1'b0, limit};
  wire logic open_w = run_ff;
  wire logic done = open_w && tick && (tmr_ff >= lim_ext) && !add_one;
  wire logic done_x = open_w && (tmr_ff > lim_ext) && add_one;
  assign expired = done || done_x;
  assign hit = edge_seen && (cnt_ff == 2'h2) && !expired;
  always_comb begin
    nxt_tmr = tmr_ff;
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    if (hit) begin
      // A run of three restarts the window, so a line that then goes quiet still times out
      nxt_cnt = 2'h0;
      nxt_tmr = '0;
      nxt_run = 1'b1;
    end else if (expired) begin
      nxt_cnt = edge_seen ? 2'h1 : 2'h0;
      nxt_tmr = '0;
      nxt_run = edge_seen;
    end else if (edge_seen) begin
      nxt_cnt = cnt_ff + 2'h1;
      if (!run_ff) begin
        nxt_tmr = '0;
        nxt_run = 1'b1;
      end
    end else if (open_w && tick && tmr_ff <= lim_ext) begin
      nxt_tmr = tmr_ff + {{W{1'b0}}, 1'b1};
    end else if (open_w && add_one && tmr_ff == lim_ext) begin
      nxt_tmr = tmr_ff + {{W{1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tmr_ff <= '0;
      cnt_ff <= 2'h0;
      run_ff <= 1'b0;
    end else begin
      tmr_ff <= nxt_tmr;
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end
endmodule

// ---- design/bmc_line_timing.sv ----
// Line timing control: squelch, idle detection, transmit bit timer, self-test enables
`timescale 1ns/1ps
`include "bmc_map.svh"
module bmc_line_timing #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [`BMC_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Receive side
  input wire logic rx_line,
  input wire logic rx_drop,
  input wire logic rx_data_in,
  input wire logic rx_data_valid_in,
  input wire logic loopback_en,
  output logic squelch,
  output logic line_active,
  output logic rx_data_out,
  output logic rx_data_valid_out,
  // Transmit side
  input wire logic tx_run,
  output logic tx_bit_strobe,
  // Self-test
  output logic selftest_receiver_enable,
  output logic selftest_enable,
  output logic selftest_rx_restart
);
  // ****************************************
  // Registers
  // ****************************************
  logic [CW-1:0] sql_assert_ff;
  logic [CW-1:0] sql_hold_ff;
  logic [CW-1:0] tx_bit_ff;
  logic [CW-1:0] idle_win_ff;
  logic [7:0] st_ctl_ff;
  wire logic hit_asrt = reg_wr && (reg_addr == `BMC_OFS_SQL_ASSERT);
  wire logic hit_hold = reg_wr && (reg_addr == `BMC_OFS_SQL_HOLD);
  wire logic hit_txb = reg_wr && (reg_addr == `BMC_OFS_TX_BIT);
  wire logic hit_idle = reg_wr && (reg_addr == `BMC_OFS_IDLE_WIN);
  wire logic hit_st = reg_wr && (reg_addr == `BMC_OFS_ST_CTL_A);
  wire logic [7:0] nxt_st = reg_wdata & `BMC_ST_WR_MASK;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sql_assert_ff <= `BMC_RST_TIMING;
      sql_hold_ff <= `BMC_RST_TIMING;
      tx_bit_ff <= `BMC_RST_TIMING;
      idle_win_ff <= `BMC_RST_TIMING;
      st_ctl_ff <= `BMC_RST_ST_CTL_A;
    end else begin
      if (hit_asrt) sql_assert_ff <= reg_wdata[CW-1:0];
      if (hit_hold) sql_hold_ff <= reg_wdata[CW-1:0];
      if (hit_txb) tx_bit_ff <= reg_wdata[CW-1:0];
      if (hit_idle) idle_win_ff <= reg_wdata[CW-1:0];
      if (hit_st) st_ctl_ff <= nxt_st;
    end
  end
  // Reserved bits and unmapped offsets read as zero
  wire logic [7:0] rd_asrt = (reg_addr == `BMC_OFS_SQL_ASSERT) ? 8'(sql_assert_ff) : 8'h00;
  wire logic [7:0] rd_hold = (reg_addr == `BMC_OFS_SQL_HOLD) ? 8'(sql_hold_ff) : 8'h00;
  wire logic [7:0] rd_txb = (reg_addr == `BMC_OFS_TX_BIT) ? 8'(tx_bit_ff) : 8'h00;
  wire logic [7:0] rd_idle = (reg_addr == `BMC_OFS_IDLE_WIN) ? 8'(idle_win_ff) : 8'h00;
  wire logic [7:0] rd_st = (reg_addr == `BMC_OFS_ST_CTL_A) ? st_ctl_ff : 8'h00;
  assign reg_rdata = rd_asrt | rd_hold | rd_txb | rd_idle | rd_st;

  // ****************************************
  // Self-test control
  // ****************************************
  logic rx_en_d_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_en_d_ff <= 1'b0;
    end else begin
      rx_en_d_ff <= st_ctl_ff[`BMC_ST_RX_EN_BIT];
    end
  end
  assign selftest_receiver_enable = st_ctl_ff[`BMC_ST_RX_EN_BIT];
  assign selftest_enable = st_ctl_ff[`BMC_ST_EN_BIT];
  // Rising edge only, so a fresh request needs a clear then a set
  assign selftest_rx_restart = st_ctl_ff[`BMC_ST_RX_EN_BIT] && !rx_en_d_ff;
  // Hard reset detection is lost too while this block is on
  wire logic rx_block = selftest_enable && loopback_en;
  assign rx_data_out = rx_block ? 1'b0 : rx_data_in;
  assign rx_data_valid_out = rx_block ? 1'b0 : rx_data_valid_in;

  // ****************************************
  // Divide-by-four tick
  // ****************************************
  logic [1:0] div_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_ff <= 2'h0;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end
  wire logic tick = (div_ff == `BMC_TICK_DIV);

  // ****************************************
  // Edge detection
  // ****************************************
  logic line_d_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_d_ff <= 1'b0;
    end else begin
      line_d_ff <= rx_line;
    end
  end
  wire logic edge_seen = rx_line ^ line_d_ff;

  // Squelch window: value x 4 + 1 clocks
  wire logic sq_hit;
  bmc_edge_window #(.W(CW)) u_sq_win (
    .clock(clock),
    .rst(rst),
    .tick(tick),
    .edge_seen(edge_seen),
    .limit(sql_assert_ff),
    .add_one(1'b1),
    .hit(sq_hit),
    .expired()
  );
  // Idle window: ends on the first tick more than value x 4 clocks after its first edge
  wire logic idle_hit;
  wire logic idle_exp;
  bmc_edge_window #(.W(CW)) u_idle_win (
    .clock(clock),
    .rst(rst),
    .tick(tick),
    .edge_seen(edge_seen),
    .limit(idle_win_ff),
    .add_one(1'b0),
    .hit(idle_hit),
    .expired(idle_exp)
  );
  logic active_ff;
  logic hold_seen_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_ff <= 1'b0;
      hold_seen_ff <= 1'b0;
    end else begin
      if (idle_hit) active_ff <= 1'b1;
      else if (idle_exp || (hold_seen_ff && tick)) active_ff <= 1'b0;
      // An idle window with no run of three is a full quiet period
      hold_seen_ff <= active_ff && !idle_hit && idle_exp;
    end
  end
  assign line_active = active_ff;

  // ****************************************
  // Squelch state and hold timer
  // ****************************************
  bmc_pkg::bmc_sq_state_t sq_ff;
  bmc_pkg::bmc_sq_state_t nxt_sq;
  logic [CW+2:0] hold_ff;
  logic [CW+2:0] nxt_hold;
  // Hold counted in clocks: value x 4 + 1
  wire logic [CW+2:0] hold_end = {1'b0, sql_hold_ff, 2'b00};
  always_comb begin
    nxt_sq = sq_ff;
    nxt_hold = hold_ff;
    case (sq_ff)
      bmc_pkg::BMC_SQ_OFF: begin
        if (sq_hit) nxt_sq = bmc_pkg::BMC_SQ_ON;
      end
      bmc_pkg::BMC_SQ_ON: begin
        // Drop decision comes from the bit-time limit checker
        if (rx_drop) begin
          nxt_sq = bmc_pkg::BMC_SQ_HOLD;
          nxt_hold = '0;
        end
      end
      bmc_pkg::BMC_SQ_HOLD: begin
        if (hold_ff >= hold_end) nxt_sq = bmc_pkg::BMC_SQ_OFF;
        else nxt_hold = hold_ff + {{(CW+2){1'b0}}, 1'b1};
      end
      default: nxt_sq = bmc_pkg::BMC_SQ_OFF;
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sq_ff <= bmc_pkg::BMC_SQ_OFF;
      hold_ff <= '0;
    end else begin
      sq_ff <= nxt_sq;
      hold_ff <= nxt_hold;
    end
  end
  assign squelch = (sq_ff != bmc_pkg::BMC_SQ_OFF);

  // ****************************************
  // Transmit bit timer
  // ****************************************
  logic [CW-1:0] bit_cnt_ff;
  logic strobe_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= '0;
      strobe_ff <= 1'b0;
    end else if (!tx_run) begin
      bit_cnt_ff <= tx_bit_ff;
      strobe_ff <= 1'b0;
    end else if (bit_cnt_ff == '0) begin
      bit_cnt_ff <= tx_bit_ff;
      strobe_ff <= 1'b1;
    end else begin
      bit_cnt_ff <= bit_cnt_ff - {{(CW-1){1'b0}}, 1'b1};
      strobe_ff <= 1'b0;
    end
  end
  assign tx_bit_strobe = strobe_ff;
endmodule

// ---- testbench/bmc_line_timing_sva.sv ----
// Property checker for the line timing block
`timescale 1ns/1ps
`include "bmc_map.svh"
module bmc_line_timing_sva (
  // Watched ports
  input wire logic clock,
  input wire logic rst,
  input wire logic [`BMC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_line,
  input wire logic rx_data_in,
  input wire logic rx_data_valid_in,
  input wire logic loopback_en,
  input wire logic squelch,
  input wire logic line_active,
  input wire logic rx_data_out,
  input wire logic rx_data_valid_out,
  input wire logic tx_run,
  input wire logic tx_bit_strobe,
  input wire logic selftest_receiver_enable,
  input wire logic selftest_enable,
  input wire logic selftest_rx_restart
);
  // Edge age saturates so a quiet line never looks like a fresh edge
  logic prev_ff;
  logic [3:0] age_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
      age_ff <= 4'hF;
    end else begin
      prev_ff <= rx_line;
      age_ff <= (rx_line != prev_ff) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hF};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rst_pulse; $rose(selftest_receiver_enable) |-> selftest_rx_restart; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("no restart");
  property p_one_pulse; selftest_rx_restart |=> !selftest_rx_restart; endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("long restart");
  property p_block; selftest_enable && loopback_en |-> !rx_data_out && !rx_data_valid_out;
  endproperty
  a_block: assert property (p_block) else $error("data leaked");
  property p_pass; !(selftest_enable && loopback_en) |->
    rx_data_out == rx_data_in && rx_data_valid_out == rx_data_valid_in; endproperty
  a_pass: assert property (p_pass) else $error("data lost");
  property p_tx_idle; !tx_run [*2] |-> !tx_bit_strobe; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("stray strobe");
  property p_sq_edge; $rose(squelch) |-> age_ff < 4'h8; endproperty
  a_sq_edge: assert property (p_sq_edge) else $error("squelch without edge");
  property p_act_edge; $rose(line_active) |-> age_ff < 4'h8; endproperty
  a_act_edge: assert property (p_act_edge) else $error("active without edge");
  property p_resv; reg_addr == `BMC_OFS_ST_CTL_A |-> reg_rdata[7:5] == 3'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
endmodule
bind bmc_line_timing bmc_line_timing_sva u_sva (.clock, .rst, .reg_addr, .reg_rdata,
  .rx_line, .rx_data_in, .rx_data_valid_in, .loopback_en, .squelch, .line_active,
  .rx_data_out, .rx_data_valid_out, .tx_run, .tx_bit_strobe, .selftest_receiver_enable,
  .selftest_enable, .selftest_rx_restart);

// ---- testbench/bmc_remote_port.sv ----
// Remote port model toggling the received line every half clocks while go is high
`timescale 1ns/1ps
module bmc_remote_port (
  // Control
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] half,
  // Line
  output logic line
);
  logic [7:0] cnt;
  initial begin
    line = 1'b0;
    cnt = 8'h00;
  end
  // The line keeps its level between frames, as a real idle line does
  always @(negedge clock) begin
    if (!go) cnt <= 8'h00;
    else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      line <= ~line;
    end else cnt <= cnt + 8'h01;
  end
endmodule

// ---- testbench/bmc_line_timing_tb_top.sv ----
// Self-checking bench for the line timing block
`timescale 1ns/1ps
`include "bmc_map.svh"
module bmc_line_timing_tb_top;
  logic clock, rst, reg_wr, rx_line, rx_drop, rx_data_in, rx_data_valid_in, loopback_en;
  logic squelch, line_active, rx_data_out, rx_data_valid_out, tx_run, tx_bit_strobe, go;
  logic selftest_receiver_enable, selftest_enable, selftest_rx_restart;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, half;
  int fail_count = 0;
  int n_checks = 0;
  int n;
  bmc_remote_port u_bmc_remote_port (.clock, .go, .half, .line(rx_line));
  bmc_line_timing u_bmc_line_timing (.clock, .rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .rx_line, .rx_drop, .rx_data_in, .rx_data_valid_in, .loopback_en,
    .squelch, .line_active, .rx_data_out, .rx_data_valid_out, .tx_run, .tx_bit_strobe,
    .selftest_receiver_enable, .selftest_enable, .selftest_rx_restart);
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, v, lo, hi);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic waitv(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v) begin
      @(negedge clock);
      k++;
      if (k > lim) begin
        fail_count++;
        $display("wrong value at %0t: got %h expected %h", $time, s, v);
        summarize();
      end
    end
  endtask
  // Each call starts on a fresh falling edge, so back-to-back writes drop the strobe for one clock between them
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    #1;
    chk(reg_rdata, e);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    logic [15:0] ofs [5] = '{`BMC_OFS_SQL_ASSERT, `BMC_OFS_SQL_HOLD, `BMC_OFS_TX_BIT,
      `BMC_OFS_IDLE_WIN, `BMC_OFS_ST_CTL_A};
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 8'hFF);
      rd(ofs[i], 8'hFF);
    end
    wr(`BMC_OFS_ST_CTL_A, 8'hE7);
    rd(`BMC_OFS_ST_CTL_A, 8'h07);
    wr(16'h1AAA, 8'h55);
    rd(16'h1AAA, 8'h00);
  endtask
  task automatic t_selftest;
    wr(`BMC_OFS_ST_CTL_A, 8'h10);
    chk({selftest_receiver_enable, selftest_rx_restart}, 8'h03);
    @(negedge clock);
    chk(selftest_rx_restart, 8'h00);
    wr(`BMC_OFS_ST_CTL_A, 8'h00);
    wr(`BMC_OFS_ST_CTL_A, 8'h10);
    chk(selftest_rx_restart, 8'h01);
    loopback_en = 1'b1;
    rx_data_in = 1'b1;
    rx_data_valid_in = 1'b1;
    wr(`BMC_OFS_ST_CTL_A, 8'h18);
    chk({selftest_enable, rx_data_out, rx_data_valid_out}, 8'h04);
    loopback_en = 1'b0;
    #1;
    chk({rx_data_out, rx_data_valid_out}, 8'h03);
    wr(`BMC_OFS_ST_CTL_A, 8'h00);
  endtask
  task automatic t_tx;
    logic [7:0] cnts [2] = '{8'h04, 8'd159};
    foreach (cnts[i]) begin
      wr(`BMC_OFS_TX_BIT, cnts[i]);
      tx_run = 1'b1;
      waitv(tx_bit_strobe, 1'b1, 300, n);
      @(negedge clock);
      waitv(tx_bit_strobe, 1'b1, 300, n);
      rng(n + 1, cnts[i] + 1, cnts[i] + 1);
      tx_run = 1'b0;
    end
  endtask
  task automatic t_rx;
    wr(`BMC_OFS_SQL_ASSERT, 8'd70);
    wr(`BMC_OFS_SQL_HOLD, 8'd23);
    wr(`BMC_OFS_IDLE_WIN, 8'd200);
    half = 8'd150;
    go = 1'b1;
    waitv(line_active, 1'b1, 900, n);
    repeat (400) @(negedge clock);
    chk(squelch, 8'h00);
    half = 8'd130;
    waitv(squelch, 1'b1, 900, n);
    go = 1'b0;
    rx_drop = 1'b1;
    @(negedge clock);
    rx_drop = 1'b0;
    waitv(squelch, 1'b0, 200, n);
    rng(n + 1, 89, 97);
    waitv(line_active, 1'b0, 810, n);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {rst, go} = 2'b10;
    {reg_wr, rx_drop, rx_data_in, rx_data_valid_in, loopback_en, tx_run} = 6'h00;
    {reg_addr, reg_wdata} = 24'h000000;
    half = 8'h01;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    t_regs();
    t_selftest();
    t_tx();
    t_rx();
    summarize();
  end
endmodule
